// ==== mior_consts.svh ====
// Constants for the multi-I/O read command logic
`ifndef MIOR_CONSTS_SVH
`define MIOR_CONSTS_SVH

// Read opcodes
`define MIOR_OP_QO          8'h6b
`define MIOR_OP_QO_WIDE     8'h6c
`define MIOR_OP_DIO         8'hbb
`define MIOR_OP_DIO_WIDE    8'hbc
`define MIOR_OP_QIO         8'heb
`define MIOR_OP_QIO_WIDE    8'hec

// Mode upper nibble that keeps continuous read
`define MIOR_MODE_CONT      4'ha

// Phase lengths in bits
`define MIOR_CMD_BITS       6'h08
`define MIOR_MODE_BITS      6'h08
`define MIOR_ADDR_SHORT     6'h18
`define MIOR_ADDR_LONG      6'h20

// Array: 8 Mbyte, byte addressed
`define MIOR_ARRAY_AW       23

// Width of the configuration word passed to the link domain
`define MIOR_CFG_W          9

`endif

// ==== mior_pkg.sv ====
// Types for the multi-I/O read command logic
package mior_pkg;

    // Link phase, one-hot
    typedef enum logic [4:0] {
        ST_CMD    = 5'h01,
        ST_ADDR   = 5'h02,
        ST_MODE   = 5'h04,
        ST_TURN   = 5'h08,
        ST_IGNORE = 5'h10
    } mior_state_t;

    // Decoded read command kind
    typedef enum logic [1:0] {
        K_NONE = 2'h0,
        K_QO   = 2'h1,
        K_DIO  = 2'h2,
        K_QIO  = 2'h3
    } mior_kind_t;

endpackage

// ==== mior_sync.sv ====
// Two-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none

module mior_sync #(
    parameter int W = 1
) (
    // Destination clock and reset
    input  wire logic         clk_i,
    input  wire logic         reset_i,
    // Levels
    input  wire logic [W-1:0] d_i,
    output var  logic [W-1:0] q_o
);

    logic [W-1:0] meta_r;

    // First flop feeds only the second
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            meta_r <= '0;
            q_o    <= '0;
        end else begin
            meta_r <= d_i;
            q_o    <= meta_r;
        end
    end

endmodule // mior_sync

`default_nettype wire

// ==== mior_array.sv ====
// Flash array: loaded on the system clock, read from the link side
`timescale 1ns/1ps
`default_nettype none
`include "mior_consts.svh"

module mior_array (
    // Load port, system clock
    input  wire logic                       clk_i,
    input  wire logic                       we_i,
    input  wire logic [`MIOR_ARRAY_AW-1:0]  waddr_i,
    input  wire logic [7:0]                 wdata_i,
    // Read port, asynchronous
    input  wire logic [`MIOR_ARRAY_AW-1:0]  raddr_i,
    output logic      [7:0]                 rdata_o
);

    logic [7:0] mem [0:(1<<`MIOR_ARRAY_AW)-1];

    // Byte load
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
    end

    assign rdata_o = mem[raddr_i];

endmodule // mior_array

`default_nettype wire

// ==== mior_read.sv ====
// Multi-I/O read command logic of a serial flash
`timescale 1ns/1ps
`default_nettype none
`include "mior_consts.svh"

module mior_read
    import mior_pkg::*;
(
    // System clock and reset
    input  wire logic                      clk_i,
    input  wire logic                      reset_i,
    // Serial link
    input  wire logic                      sck_i,
    input  wire logic                      cs_n_i,
    input  wire logic [3:0]                io_i,
    output var  logic [3:0]                io_o,
    output var  logic [3:0]                io_oe_o,
    // Configuration
    input  wire logic                      address_length_bit_i,
    input  wire logic [3:0]                latency_code_field_i,
    input  wire logic                      quad_enable_bit_i,
    input  wire logic                      four_wire_enable_bit_i,
    input  wire logic                      four_bit_instr_mode_bit_i,
    input  wire logic                      mode_reset_i,
    // Array load
    input  wire logic                      load_en_i,
    input  wire logic [`MIOR_ARRAY_AW-1:0] load_addr_i,
    input  wire logic [7:0]                load_data_i,
    // Status
    output var  logic                      cont_mode_o,
    output var  logic                      cont_quad_o
);

    //--------------------------------------------------------------------
    // System clock side
    //--------------------------------------------------------------------

    logic [`MIOR_CFG_W-1:0] cfg_r;
    logic [`MIOR_CFG_W-1:0] cfg_nxt;
    logic                   tog_r;
    logic                   tog_nxt;

    // Config word and mode reset toggle
    always_comb begin
        tog_nxt = tog_r ^ mode_reset_i;
        cfg_nxt = {tog_r, four_bit_instr_mode_bit_i,
                   four_wire_enable_bit_i, quad_enable_bit_i,
                   address_length_bit_i, latency_code_field_i};
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            cfg_r <= '0;
            tog_r <= 1'b0;
        end else begin
            cfg_r <= cfg_nxt;
            tog_r <= tog_nxt;
        end
    end

    //--------------------------------------------------------------------
    // Crossings
    //--------------------------------------------------------------------

    logic [`MIOR_CFG_W-1:0] cfg_s;
    logic                   cont_r;
    logic [7:0]             cont_cmd_r;
    logic                   cont_quad;

    // Config into the link domain
    mior_sync #(.W(`MIOR_CFG_W)) u_cfg_sync (
        .clk_i   (sck_i),
        .reset_i (reset_i),
        .d_i     (cfg_r),
        .q_o     (cfg_s)
    );

    assign cont_quad = (cont_cmd_r == `MIOR_OP_QIO) ||
                       (cont_cmd_r == `MIOR_OP_QIO_WIDE);

    // Continuous state back to the system clock
    mior_sync #(.W(2)) u_stat_sync (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .d_i     ({cont_r, cont_r & cont_quad}),
        .q_o     ({cont_mode_o, cont_quad_o})
    );

    logic       tog_s;
    logic       cf_qpi;
    logic       cf_fwe;
    logic       cf_qe;
    logic       cf_al;
    logic [3:0] cf_lc;

    assign {tog_s, cf_qpi, cf_fwe, cf_qe, cf_al, cf_lc} = cfg_s;

    //--------------------------------------------------------------------
    // Command decode
    //--------------------------------------------------------------------

    function automatic mior_kind_t op_kind(input logic [7:0] op,
                                           input logic       quad_ok);
        mior_kind_t k;
        k = K_NONE;
        case (op)
            `MIOR_OP_QO, `MIOR_OP_QO_WIDE:   k = K_QO;
            `MIOR_OP_DIO, `MIOR_OP_DIO_WIDE: k = K_DIO;
            `MIOR_OP_QIO, `MIOR_OP_QIO_WIDE: k = quad_ok ? K_QIO : K_NONE;
            default:                         k = K_NONE;
        endcase
        return k;
    endfunction

    //--------------------------------------------------------------------
    // Link input side, rising edge of sck
    //--------------------------------------------------------------------

    // Frame reset: chip select high ends the frame
    logic frame_rst;
    assign frame_rst = reset_i | cs_n_i;

    mior_state_t state_r;
    mior_state_t state_nxt;
    logic [5:0]  cnt_r;
    logic [5:0]  cnt_nxt;
    logic [7:0]  cmd_r;
    logic [7:0]  cmd_nxt;
    logic [31:0] addr_r;
    logic [31:0] addr_nxt;
    logic [7:0]  mode_r;
    logic [7:0]  mode_nxt;
    logic        cap;
    logic        seen_r;
    logic        eff_cont;
    logic        in_addr;
    logic [7:0]  cur_cmd;
    mior_kind_t  kind;
    logic        wide;
    logic [5:0]  aw;
    logic [5:0]  abits;

    // Pending mode reset hides continuous mode at once
    assign eff_cont = cont_r & (tog_s == seen_r);
    assign cur_cmd  = (state_r == ST_CMD && eff_cont) ? cont_cmd_r : cmd_r;
    assign kind     = op_kind(cur_cmd, cf_qe | cf_fwe);
    assign wide     = (cur_cmd == `MIOR_OP_QO_WIDE) ||
                      (cur_cmd == `MIOR_OP_DIO_WIDE) ||
                      (cur_cmd == `MIOR_OP_QIO_WIDE);
    assign aw       = (wide | cf_al) ? `MIOR_ADDR_LONG
                                     : `MIOR_ADDR_SHORT;
    assign abits    = (kind == K_QIO) ? 6'h04 :
                      (kind == K_DIO) ? 6'h02 : 6'h01;
    // Continuous frames open straight with the address
    assign in_addr  = (state_r == ST_ADDR) ||
                      (state_r == ST_CMD && eff_cont);

    // Phase sequencing
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        cmd_nxt   = cmd_r;
        addr_nxt  = addr_r;
        mode_nxt  = mode_r;
        cap       = 1'b0;
        case (state_r)
            ST_CMD: begin
                if (eff_cont) begin
                    cmd_nxt = cont_cmd_r;
                end else begin
                    // Four-bit opcode transfer when enabled
                    if (cf_qpi) begin
                        cmd_nxt = {cmd_r[3:0], io_i};
                        cnt_nxt = cnt_r + 6'h04;
                    end else begin
                        cmd_nxt = {cmd_r[6:0], io_i[0]};
                        cnt_nxt = cnt_r + 6'h01;
                    end
                    if (cnt_nxt == `MIOR_CMD_BITS) begin
                        cnt_nxt   = 6'h00;
                        state_nxt = (op_kind(cmd_nxt, cf_qe | cf_fwe)
                                     == K_NONE) ? ST_IGNORE : ST_ADDR;
                    end
                end
            end
            ST_MODE: begin
                // Dual: 4 clocks of 2 bits; quad: 2 clocks of 4 bits
                if (kind == K_QIO) begin
                    mode_nxt = {mode_r[3:0], io_i};
                end else begin
                    mode_nxt = {mode_r[5:0], io_i[1:0]};
                end
                cnt_nxt = cnt_r + abits;
                if (cnt_nxt == `MIOR_MODE_BITS) begin
                    cnt_nxt   = 6'h00;
                    state_nxt = ST_TURN;
                    cap       = 1'b1;
                end
            end
            ST_ADDR, ST_TURN, ST_IGNORE: begin
                // Host lines ignored in turnaround
                state_nxt = state_r;
            end
            default: begin
                state_nxt = ST_IGNORE;
            end
        endcase
        // Address shift, MSB first, width per command
        if (in_addr) begin
            case (abits)
                6'h04:   addr_nxt = {addr_r[27:0], io_i};
                6'h02:   addr_nxt = {addr_r[29:0], io_i[1:0]};
                default: addr_nxt = {addr_r[30:0], io_i[0]};
            endcase
            cnt_nxt   = cnt_r + abits;
            state_nxt = ST_ADDR;
            if (cnt_nxt == aw) begin
                cnt_nxt   = 6'h00;
                state_nxt = (kind == K_QO) ? ST_TURN : ST_MODE;
            end
        end
    end

    always_ff @(posedge sck_i or posedge frame_rst) begin
        if (frame_rst) begin
            state_r <= ST_CMD;
            cnt_r   <= 6'h00;
            cmd_r   <= 8'h00;
            addr_r  <= 32'h0000_0000;
            mode_r  <= 8'h00;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            cmd_r   <= cmd_nxt;
            addr_r  <= addr_nxt;
            mode_r  <= mode_nxt;
        end
    end

    //--------------------------------------------------------------------
    // Continuous read state, kept across frames
    //--------------------------------------------------------------------

    logic       cont_nxt;
    logic [7:0] cont_cmd_nxt;
    logic       seen_nxt;

    // Mode capture wins over a pending mode reset
    always_comb begin
        cont_nxt     = cont_r;
        cont_cmd_nxt = cont_cmd_r;
        seen_nxt     = tog_s;
        if (cap) begin
            // Only the upper nibble decides
            cont_nxt     = (mode_nxt[7:4] == `MIOR_MODE_CONT);
            cont_cmd_nxt = cmd_r;
        end else if (tog_s != seen_r) begin
            cont_nxt = 1'b0;
        end
    end

    always_ff @(posedge sck_i or posedge reset_i) begin
        if (reset_i) begin
            cont_r     <= 1'b0;
            cont_cmd_r <= 8'h00;
            seen_r     <= 1'b0;
        end else begin
            cont_r     <= cont_nxt;
            cont_cmd_r <= cont_cmd_nxt;
            seen_r     <= seen_nxt;
        end
    end

    //--------------------------------------------------------------------
    // Link output side, falling edge of sck
    //--------------------------------------------------------------------

    logic [3:0]                ncnt_r;
    logic [3:0]                ncnt_nxt;
    logic                      on_r;
    logic                      on_nxt;
    logic [1:0]                grp_r;
    logic [1:0]                grp_nxt;
    logic [7:0]                byte_r;
    logic [7:0]                byte_nxt;
    logic [`MIOR_ARRAY_AW-1:0] rda_r;
    logic [`MIOR_ARRAY_AW-1:0] rda_nxt;
    logic [`MIOR_ARRAY_AW-1:0] fetch_addr;
    logic [7:0]                rd_data;
    logic [3:0]                io_nxt;
    logic [3:0]                oe_nxt;
    logic                      emit;
    logic                      w4;
    logic [7:0]                sh;

    assign w4         = (kind != K_DIO);
    assign fetch_addr = on_r ? rda_r : addr_r[`MIOR_ARRAY_AW-1:0];

    mior_array u_array (
        .clk_i   (clk_i),
        .we_i    (load_en_i),
        .waddr_i (load_addr_i),
        .wdata_i (load_data_i),
        .raddr_i (fetch_addr),
        .rdata_o (rd_data)
    );

    // Dummy count and data shifting
    always_comb begin
        ncnt_nxt = ncnt_r;
        on_nxt   = on_r;
        grp_nxt  = grp_r;
        byte_nxt = byte_r;
        rda_nxt  = rda_r;
        io_nxt   = io_o;
        oe_nxt   = io_oe_o;
        emit     = 1'b0;
        sh       = (grp_r == 2'h0) ? rd_data : byte_r;
        // One dummy per falling edge until the latency is met
        if (state_r == ST_TURN) begin
            if (on_r) begin
                emit = 1'b1;
            end else if (ncnt_r == cf_lc) begin
                emit   = 1'b1;
                on_nxt = 1'b1;
            end else begin
                ncnt_nxt = ncnt_r + 4'h1;
            end
        end
        if (emit) begin
            if (grp_r == 2'h0) begin
                rda_nxt = fetch_addr + 1'b1;
            end
            // MSB first, top line carries the top bit
            if (w4) begin
                io_nxt   = sh[7:4];
                oe_nxt   = 4'hf;
                byte_nxt = {sh[3:0], 4'h0};
            end else begin
                io_nxt   = {2'h0, sh[7:6]};
                oe_nxt   = 4'h3;
                byte_nxt = {sh[5:0], 2'h0};
            end
            grp_nxt = (grp_r == (w4 ? 2'h1 : 2'h3)) ? 2'h0 : grp_r + 2'h1;
        end
    end

    // Drivers drop as soon as chip select rises
    always_ff @(negedge sck_i or posedge frame_rst) begin
        if (frame_rst) begin
            ncnt_r  <= 4'h0;
            on_r    <= 1'b0;
            grp_r   <= 2'h0;
            byte_r  <= 8'h00;
            rda_r   <= '0;
            io_o    <= 4'h0;
            io_oe_o <= 4'h0;
        end else begin
            ncnt_r  <= ncnt_nxt;
            on_r    <= on_nxt;
            grp_r   <= grp_nxt;
            byte_r  <= byte_nxt;
            rda_r   <= rda_nxt;
            io_o    <= io_nxt;
            io_oe_o <= oe_nxt;
        end
    end

endmodule // mior_read

`default_nettype wire

// ==== mior_read_props.sv ====
// Concurrent checks on the ports of the multi-I/O read logic
`timescale 1ns/1ps
`default_nettype none

module mior_read_props (
    // Clocks and reset
    input  wire logic       clk_i,
    input  wire logic       reset_i,
    input  wire logic       sck_i,
    // Link
    input  wire logic       cs_n_i,
    input  wire logic [3:0] io_oe_o,
    // Mode control and status
    input  wire logic       mode_reset_i,
    input  wire logic       cont_mode_o,
    input  wire logic       cont_quad_o
);
    // ----------------------------------------
    // Rising edges seen in the frame, capped
    // ----------------------------------------
    logic [3:0] rise_cnt_r;
    logic [3:0] rise_cnt_nxt;

    // Cap at eight, enough for the earliest data
    always_comb begin
        rise_cnt_nxt = (rise_cnt_r == 4'h8) ? rise_cnt_r : rise_cnt_r + 4'h1;
    end

    // Cleared while deselected
    always_ff @(posedge sck_i or posedge reset_i or posedge cs_n_i) begin
        if (reset_i || cs_n_i) begin
            rise_cnt_r <= 4'h0;
        end else begin
            rise_cnt_r <= rise_cnt_nxt;
        end
    end

    oe_idle_a: assert property (@(posedge clk_i) disable iff (reset_i)
        cs_n_i |-> io_oe_o == 4'h0)
        else $error("Drive seen while deselected");
    oe_codes_a: assert property (@(posedge clk_i) disable iff (reset_i)
        io_oe_o inside {4'h0, 4'h3, 4'hf})
        else $error("Output enable not a data width");
    oe_late_a: assert property (@(negedge sck_i) disable iff (reset_i || cs_n_i)
        io_oe_o != 4'h0 |-> rise_cnt_r == 4'h8)
        else $error("Drive before address and mode done");
    oe_first_a: assert property (@(posedge sck_i) disable iff (reset_i || cs_n_i)
        rise_cnt_r < 4'h8 |-> io_oe_o == 4'h0)
        else $error("Drive during opcode or address");
    oe_steady_a: assert property (@(posedge sck_i) disable iff (reset_i || cs_n_i)
        (rise_cnt_r != 4'h0 && $past(io_oe_o) != 4'h0)
        |-> io_oe_o == $past(io_oe_o))
        else $error("Data width changed in a frame");
    data_stop_a: assert property (@(posedge clk_i) disable iff (reset_i)
        $fell(io_oe_o != 4'h0) |-> cs_n_i)
        else $error("Data stopped while selected");
    reset_clear_a: assert property (@(posedge clk_i) disable iff (reset_i)
        $fell(reset_i) |-> io_oe_o == 4'h0 && !cont_mode_o && !cont_quad_o)
        else $error("Outputs not clear after reset");
    mode_reset_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (mode_reset_i && cs_n_i) ##1 cs_n_i [*8] |-> !cont_mode_o)
        else $error("Mode reset left continuous read");
endmodule // mior_read_props

bind mior_read mior_read_props mior_read_props_i (
    .clk_i        (clk_i),
    .reset_i      (reset_i),
    .sck_i        (sck_i),
    .cs_n_i       (cs_n_i),
    .io_oe_o      (io_oe_o),
    .mode_reset_i (mode_reset_i),
    .cont_mode_o  (cont_mode_o),
    .cont_quad_o  (cont_quad_o)
);

`default_nettype wire

// ==== mior_host.sv ====
// Host controller model driving read frames on the link
`timescale 1ns/1ps
`default_nettype none

module mior_host (
    // Link to the device
    output var  logic       sck_o,
    output var  logic       cs_n_o,
    output var  logic [3:0] pin_o,
    // Device drive
    input  wire logic [3:0] dev_d_i,
    input  wire logic [3:0] dev_oe_i
);
    logic [3:0] hd;
    logic       h_oe;
    logic [3:0] junk;
    logic [3:0] smp;
    bit         drv;

    // Wire level: host, else device, else a floating pattern
    assign pin_o = h_oe ? hd : ((dev_d_i & dev_oe_i) | (junk & ~dev_oe_i));

    // Idle link, clock low
    initial begin
        sck_o = 1'b0;
        cs_n_o = 1'b1;
        hd = 4'h0;
        h_oe = 1'b0;
        junk = 4'h5;
    end

    // One link cycle: rise samples, fall lets the device move
    task automatic cyc();
        #16 sck_o = 1'b1;
        smp = pin_o;
        drv = drv | (|dev_oe_i);
        #16 sck_o = 1'b0;
        junk = ~junk;
    endtask

    // Clock toggles with the device deselected
    task automatic idle(input int n);
        repeat (n) cyc();
    endtask

    // Shift a value out MSB first, w lines per clock
    task automatic put(input logic [31:0] v, input int nb, input int w);
        for (int i = nb / w - 1; i >= 0; i--) begin
            hd = 4'((v >> (i * w)) & ((32'h1 << w) - 32'h1));
            cyc();
        end
    endtask

    // Whole read frame, six data bytes returned
    task automatic frame(input bit on, input bit four_bit_instruction_mode, input logic [7:0] op,
        input logic [31:0] a, input int ab, input int aw,
        input logic [7:0] md, input int mw, input int lc,
        input int dw, output logic [7:0] q[6], output bit d);
        logic [7:0] b;
        drv = 1'b0;
        cs_n_o = 1'b0;
        h_oe = 1'b1;
        if (on) put(32'(op), 8, four_bit_instruction_mode ? 4 : 1);
        put(a, ab, aw);
        if (mw != 0) begin
            put(32'(md[7:4]), 4, mw);
            h_oe = 1'b0;
            put(32'(md[3:0]), 4, mw);
        end
        h_oe = 1'b0;
        repeat (lc) cyc();
        for (int k = 0; k < 6; k++) begin
            b = 8'h00;
            repeat (8 / dw) begin
                cyc();
                b = 8'((b << dw) | 8'(smp & 4'((1 << dw) - 1)));
            end
            q[k] = b;
        end
        #8 cs_n_o = 1'b1;
        d = drv;
        // Deselect longer than one system clock, so checks see it
        #48;
    endtask
endmodule // mior_host

`default_nettype wire

// ==== mior_read_bench.sv ====
// Self-checking bench for the multi-I/O read command logic
`timescale 1ns/1ps
`default_nettype none

module mior_read_bench;
    logic        clk_i, reset_i, sck, cs_n, alen, qe, fwe, four_bit_instruction_mode, mrst;
    logic        ld_en, cmode, cquad;
    logic [3:0]  pin, dio, doe, lc;
    logic [22:0] ld_a;
    logic [7:0]  ld_d;
    int          errors, checks_done, cycles;

    mior_read mior_read_i (.clk_i(clk_i), .reset_i(reset_i), .sck_i(sck),
        .cs_n_i(cs_n), .io_i(pin), .io_o(dio), .io_oe_o(doe),
        .address_length_bit_i(alen), .latency_code_field_i(lc),
        .quad_enable_bit_i(qe), .four_wire_enable_bit_i(fwe),
        .four_bit_instr_mode_bit_i(four_bit_instruction_mode), .mode_reset_i(mrst),
        .load_en_i(ld_en), .load_addr_i(ld_a), .load_data_i(ld_d),
        .cont_mode_o(cmode), .cont_quad_o(cquad));
    mior_host mior_host_i (.sck_o(sck), .cs_n_o(cs_n), .pin_o(pin),
        .dev_d_i(dio), .dev_oe_i(doe));

    // System clock, 25 ns
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    // Hang guard
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            end_sim();
        end
    end

    function automatic logic [7:0] pat(input logic [22:0] a);
        return a[7:0] ^ a[22:15] ^ 8'h3c;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Config change, then idle clocks so the link side settles
    task automatic cfg(input logic al, input logic [3:0] l, input logic q,
        input logic f, input logic p);
        @(posedge clk_i);
        alen <= al;
        lc <= l;
        qe <= q;
        fwe <= f;
        four_bit_instruction_mode <= p;
        @(posedge clk_i);
        mior_host_i.idle(4);
    endtask

    task automatic load(input logic [22:0] a);
        @(posedge clk_i);
        ld_en <= 1'b1;
        ld_a <= a;
        ld_d <= pat(a);
    endtask

    // One read frame, six bytes compared from the start address
    task automatic rd(input bit on, input logic [7:0] op,
        input logic [31:0] a, input int ab, input int aw,
        input logic [7:0] md, input int mw, input int dw);
        logic [7:0] q[6];
        bit d;
        mior_host_i.frame(on, four_bit_instruction_mode, op, a, ab, aw, md, mw, int'(lc), dw, q, d);
        for (int k = 0; k < 6; k++)
            chk(32'(q[k]), 32'(pat(a[22:0] + 23'(k))));
    endtask

    // Main sequence
    initial begin
        logic [7:0] q[6];
        bit d;
        {reset_i, alen, qe, fwe, four_bit_instruction_mode, mrst, ld_en} = 7'h40;
        {lc, ld_a, ld_d} = '0;
        repeat (6) @(posedge clk_i);
        reset_i <= 1'b0;
        for (int i = 0; i < 12; i++) load(23'h7ffffc + 23'(i));
        for (int i = 0; i < 16; i++) load(23'h123450 + 23'(i));
        @(posedge clk_i);
        ld_en <= 1'b0;
        cfg(1'b0, 4'h3, 1'b0, 1'b0, 1'b0);
        rd(1'b1, 8'h6b, 32'h007ffffd, 24, 1, 8'h00, 0, 4);
        rd(1'b1, 8'h6c, 32'hff123450, 32, 1, 8'h00, 0, 4);
        cfg(1'b1, 4'h0, 1'b0, 1'b0, 1'b0);
        rd(1'b1, 8'h6b, 32'h80123451, 32, 1, 8'h00, 0, 4);
        rd(1'b1, 8'hbb, 32'h00123452, 32, 2, 8'h00, 2, 2);
        cfg(1'b0, 4'h2, 1'b0, 1'b0, 1'b0);
        rd(1'b1, 8'hbc, 32'h7f123453, 32, 2, 8'ha5, 2, 2);
        repeat (4) @(posedge clk_i);
        chk(32'(cmode), 32'h1);
        chk(32'(cquad), 32'h0);
        rd(1'b0, 8'h00, 32'h00123454, 32, 2, 8'h50, 2, 2);
        repeat (4) @(posedge clk_i);
        chk(32'(cmode), 32'h0);
        rd(1'b1, 8'hbb, 32'h00123455, 24, 2, 8'hff, 2, 2);
        cfg(1'b0, 4'h4, 1'b0, 1'b0, 1'b0);
        mior_host_i.frame(1'b1, 1'b0, 8'heb, 32'h00123456, 24, 4, 8'h00, 4,
            4, 4, q, d);
        chk(32'(d), 32'h0);
        cfg(1'b0, 4'h4, 1'b1, 1'b0, 1'b0);
        rd(1'b1, 8'heb, 32'h00123456, 24, 4, 8'h00, 4, 4);
        cfg(1'b0, 4'h1, 1'b0, 1'b1, 1'b1);
        rd(1'b1, 8'heb, 32'h00123457, 24, 4, 8'ha0, 4, 4);
        repeat (4) @(posedge clk_i);
        chk(32'(cquad), 32'h1);
        rd(1'b0, 8'h00, 32'h00123458, 24, 4, 8'ha3, 4, 4);
        @(posedge clk_i);
        mrst <= 1'b1;
        @(posedge clk_i);
        mrst <= 1'b0;
        mior_host_i.idle(8);
        chk(32'(cmode), 32'h0);
        chk(32'(cquad), 32'h0);
        rd(1'b1, 8'hec, 32'h12123459, 32, 4, 8'h00, 4, 4);
        end_sim();
    end
endmodule // mior_read_bench

`default_nettype wire
